// File: design/tmo_params.svh
// constants of the 8-bit compare timer output block: offsets, fields, resets
// assumes inclusion by bare name from the package and the checker
`ifndef TMO_PARAMS_SVH
`define TMO_PARAMS_SVH

// ----------------------------------------
// register offsets (word index on the plain port)
// ----------------------------------------
`define TMO_ADDR_W 3
`define TMO_OFF_CTRL 3'h0
`define TMO_OFF_CSR 3'h1
`define TMO_OFF_CONST_A 3'h2
`define TMO_OFF_CONST_B 3'h3
`define TMO_OFF_COUNT 3'h4
`define TMO_OFF_INT_STAT 3'h5
`define TMO_OFF_INT_MASK 3'h6
`define TMO_OFF_SER_SRC 3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define TMO_CTRL_CKS_LO 0
`define TMO_CTRL_CKS_HI 1
`define TMO_CTRL_CLR_LO 3
`define TMO_CTRL_CLR_HI 4
`define TMO_CSR_FLAG_LO 5
`define TMO_CSR_FLAG_HI 7
`define TMO_CSR_OSA_LO 0
`define TMO_CSR_OSA_HI 1
`define TMO_CSR_OSB_LO 2
`define TMO_CSR_OSB_HI 3
`define TMO_EV_MATCH_A 0
`define TMO_EV_MATCH_B 1
`define TMO_EV_OVF 2

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define TMO_CLR_ON_A 2'b01
`define TMO_CLR_ON_B 2'b10
`define TMO_SER_SRC_TIMER 4'h4
`define TMO_COUNT_MAX 8'hff
`define TMO_RST_BYTE 8'h00
`define TMO_RST_EV 3'h0
`define TMO_RST_NIB 4'h0

// ----------------------------------------
// timing counts: count clock dividers in core cycles
// ----------------------------------------
`define TMO_DIV_MID 8
`define TMO_DIV_SLOW 64

`endif

// File: design/tmo_pkg.sv
// types shared by the compare timer output modules
// assumes tmo_params.svh on the include path
package tmo_pkg;
`include "tmo_params.svh"

   typedef enum logic [1:0] {
      TMO_CKS_STOP = 2'b00,
      TMO_CKS_FULL = 2'b01,
      TMO_CKS_MID = 2'b10,
      TMO_CKS_SLOW = 2'b11
   } tmo_cks_type;

   typedef struct packed {
      logic [`TMO_ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmo_bus_type;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [2:0] flags;
      logic [3:0] osel;
      logic [7:0] const_a;
      logic [7:0] const_b;
      logic [7:0] count;
      logic [2:0] int_stat;
      logic [2:0] int_mask;
      logic [3:0] ser_src;
      logic tmo;
      logic tmo_oe;
      logic irq;
      logic ser_clk;
      logic [7:0] rdata;
   } tmo_state_type;

   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } tmo_pre_state_type;
endpackage

// File: design/tmo_prescale.sv
// count clock divider: one-cycle enable pulse at the selected rate
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/10ps
module tmo_prescale
   import tmo_pkg::*;
#(
   parameter int DIV_MID = `TMO_DIV_MID,
   parameter int DIV_SLOW = `TMO_DIV_SLOW
) (
   input wire logic clk,
   input wire logic rst,
   input wire tmo_cks_type sel,
   output logic tick
);
   initial begin
      if (DIV_MID < 2 || DIV_SLOW < 2 || DIV_SLOW > 65535) begin
         $error("tmo_prescale: divider out of range");
      end
   end

   tmo_pre_state_type state_ff;
   tmo_pre_state_type nxt_state;

   // ----------------------------------------
   // divider
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_state.cnt = state_ff.cnt + 16'h0001;
      nxt_state.tick = 1'b0;
      case (sel)
         TMO_CKS_STOP: begin
            nxt_state.cnt = 16'h0000;
         end
         TMO_CKS_FULL: begin
            nxt_state.tick = 1'b1;
            nxt_state.cnt = 16'h0000;
         end
         TMO_CKS_MID: begin
            if (state_ff.cnt >= 16'(DIV_MID - 1)) begin
               nxt_state.cnt = 16'h0000;
               nxt_state.tick = 1'b1;
            end
         end
         TMO_CKS_SLOW: begin
            if (state_ff.cnt >= 16'(DIV_SLOW - 1)) begin
               nxt_state.cnt = 16'h0000;
               nxt_state.tick = 1'b1;
            end
         end
         default: begin
            nxt_state.cnt = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign tick = state_ff.tick;
endmodule

// File: design/tmo_timer.sv
// 8-bit compare timer with set/clear/toggle output and register port
// assumes one 40 MHz core clock, synchronous high reset, master on same clock
`timescale 1ns/10ps

module tmo_timer
   import tmo_pkg::*;
#(
   parameter int DIV_MID = `TMO_DIV_MID,
   parameter int DIV_SLOW = `TMO_DIV_SLOW
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [`TMO_ADDR_W-1:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic TIMER_OUT_PIN,
   output logic TIMER_OUT_PIN_OE,
   output logic SER_BASE_CLK,
   output logic IRQ
);
   initial begin
      if (DIV_MID >= DIV_SLOW) begin
         $error("tmo_timer: slow divider must exceed mid divider");
      end
   end

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic out_action(input logic cur, input logic [1:0] sel);
      logic res;
      res = cur;
      case (sel)
         2'b00: res = cur;
         2'b01: res = 1'b0;
         2'b10: res = 1'b1;
         2'b11: res = ~cur;
         default: res = cur;
      endcase
      return res;
   endfunction

   function automatic logic [7:0] read_mux(input tmo_state_type s,
                                           input logic [`TMO_ADDR_W-1:0] a);
      logic [7:0] res;
      res = 8'h00;
      case (a)
         `TMO_OFF_CTRL: res = s.ctrl;
         `TMO_OFF_CSR: res = {s.flags, 1'b0, s.osel};
         `TMO_OFF_CONST_A: res = s.const_a;
         `TMO_OFF_CONST_B: res = s.const_b;
         `TMO_OFF_COUNT: res = s.count;
         `TMO_OFF_INT_STAT: res = {5'h00, s.int_stat};
         `TMO_OFF_INT_MASK: res = {5'h00, s.int_mask};
         `TMO_OFF_SER_SRC: res = {4'h0, s.ser_src};
         default: res = 8'h00;
      endcase
      return res;
   endfunction

   // ----------------------------------------
   // state and inputs
   // ----------------------------------------
   tmo_state_type state_ff;
   tmo_state_type nxt_state;
   tmo_bus_type bus;
   logic count_tick;
   logic [1:0] clr_sel;
   logic match_a;
   logic match_b;
   logic ovf;
   logic [2:0] events;
   logic wr_ctrl;
   logic wr_csr;
   logic out_val;

   assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
   assign clr_sel = state_ff.ctrl[`TMO_CTRL_CLR_HI:`TMO_CTRL_CLR_LO];

   tmo_prescale #(
      .DIV_MID(DIV_MID),
      .DIV_SLOW(DIV_SLOW)
   ) u_prescale (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .sel(tmo_cks_type'(state_ff.ctrl[`TMO_CTRL_CKS_HI:`TMO_CTRL_CKS_LO])),
      .tick(count_tick)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      wr_ctrl = bus.wr && (bus.addr == `TMO_OFF_CTRL);
      wr_csr = bus.wr && (bus.addr == `TMO_OFF_CSR);

      // compare against constants at each count clock
      match_a = count_tick && (state_ff.count == state_ff.const_a);
      match_b = count_tick && (state_ff.count == state_ff.const_b);
      ovf = count_tick && (state_ff.count == `TMO_COUNT_MAX)
            && !(match_a && clr_sel == `TMO_CLR_ON_A)
            && !(match_b && clr_sel == `TMO_CLR_ON_B);
      events = 3'h0;
      events[`TMO_EV_MATCH_A] = match_a;
      events[`TMO_EV_MATCH_B] = match_b;
      events[`TMO_EV_OVF] = ovf;

      // counter: clear on match per select, else count up
      if (count_tick) begin
         if (match_a && clr_sel == `TMO_CLR_ON_A) begin
            nxt_state.count = 8'h00;
         end else if (match_b && clr_sel == `TMO_CLR_ON_B) begin
            nxt_state.count = 8'h00;
         end else begin
            nxt_state.count = state_ff.count + 8'h01;
         end
      end
      if (bus.wr && bus.addr == `TMO_OFF_COUNT) begin
         nxt_state.count = bus.wdata;
      end

      // output pin: A action then B action; stays 0 until a match
      out_val = state_ff.tmo;
      if (match_a) begin
         out_val = out_action(out_val, state_ff.osel[`TMO_CSR_OSA_HI:`TMO_CSR_OSA_LO]);
      end
      if (match_b) begin
         out_val = out_action(out_val, state_ff.osel[`TMO_CSR_OSB_HI:`TMO_CSR_OSB_LO]);
      end
      nxt_state.tmo = out_val;

      // simple registers
      if (wr_ctrl) begin
         nxt_state.ctrl = bus.wdata;
      end
      if (bus.wr && bus.addr == `TMO_OFF_CONST_A) begin
         nxt_state.const_a = bus.wdata;
      end
      if (bus.wr && bus.addr == `TMO_OFF_CONST_B) begin
         nxt_state.const_b = bus.wdata;
      end
      if (bus.wr && bus.addr == `TMO_OFF_SER_SRC) begin
         nxt_state.ser_src = bus.wdata[3:0];
      end
      if (bus.wr && bus.addr == `TMO_OFF_INT_MASK) begin
         nxt_state.int_mask = bus.wdata[2:0];
      end

      // status flags: written zero clears, new event wins
      nxt_state.flags = state_ff.flags;
      if (wr_csr) begin
         nxt_state.flags = state_ff.flags & bus.wdata[`TMO_CSR_FLAG_HI:`TMO_CSR_FLAG_LO];
         nxt_state.osel = bus.wdata[3:0];
      end
      nxt_state.flags = nxt_state.flags | {match_b, match_a, ovf};

      // interrupt status: write one clears, event wins
      nxt_state.int_stat = state_ff.int_stat;
      if (bus.wr && bus.addr == `TMO_OFF_INT_STAT) begin
         nxt_state.int_stat = state_ff.int_stat & ~bus.wdata[2:0];
      end
      nxt_state.int_stat = nxt_state.int_stat | events;
      nxt_state.irq = |(nxt_state.int_stat & nxt_state.int_mask);

      // pin enable follows the output selects
      nxt_state.tmo_oe = |nxt_state.osel;

      // serial base clock from the match output
      if (nxt_state.ser_src == `TMO_SER_SRC_TIMER) begin
         nxt_state.ser_clk = nxt_state.tmo;
      end else begin
         nxt_state.ser_clk = 1'b0;
      end

      // read data one cycle after the strobe, else zero
      if (bus.rd) begin
         nxt_state.rdata = read_mux(state_ff, bus.addr);
      end else begin
         nxt_state.rdata = 8'h00;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign REG_RDATA = state_ff.rdata;
   assign TIMER_OUT_PIN = state_ff.tmo & state_ff.tmo_oe;
   assign TIMER_OUT_PIN_OE = state_ff.tmo_oe;
   assign SER_BASE_CLK = state_ff.ser_clk;
   assign IRQ = state_ff.irq;
endmodule

// File: sim/tmo_pin_mon.sv
// pin watcher: lengths of the last high and low runs, count of rises
// assumes the pin is sampled on the core clock
`timescale 1ns/10ps
module tmo_pin_mon (
   input wire logic clk,
   input wire logic clr,
   input wire logic pin,
   output logic [7:0] hi_len,
   output logic [7:0] lo_len,
   output logic [7:0] rises
);
   logic [7:0] run;
   logic last;
   // ----------------------------------------
   // run length measure
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (clr) begin
         run <= 8'h00;
         rises <= 8'h00;
         hi_len <= 8'h00;
         lo_len <= 8'h00;
         last <= pin;
      end else if (pin != last) begin
         if (last) begin
            hi_len <= run + 8'h01;
         end else begin
            lo_len <= run + 8'h01;
         end
         rises <= rises + {7'h00, pin};
         run <= 8'h00;
         last <= pin;
      end else begin
         run <= run + 8'h01;
      end
   end
endmodule

// File: sim/tmo_timer_props.sv
// port checker of the compare timer
// assumes binding onto tmo_timer
`timescale 1ns/10ps
`include "tmo_params.svh"
module tmo_timer_props
   import tmo_pkg::*;
#(
   parameter int DIV_MID = 8,
   parameter int DIV_SLOW = 64
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [`TMO_ADDR_W-1:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic TIMER_OUT_PIN,
   input wire logic TIMER_OUT_PIN_OE,
   input wire logic SER_BASE_CLK,
   input wire logic IRQ
);
   logic [7:0] msk_ff;
   logic [7:0] ca_ff;
   // ----------------------------------------
   // shadows of written registers
   // ----------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         msk_ff <= 8'h00;
         ca_ff <= 8'h00;
      end else if (REG_WR && REG_ADDR == 3'h6) begin
         msk_ff <= {5'h00, REG_WDATA[2:0]};
      end else if (REG_WR && REG_ADDR == 3'h2) begin
         ca_ff <= REG_WDATA;
      end
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   AST_RD_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data not zero outside read slot");
   AST_MASK_RD: assert property (REG_RD && REG_ADDR == 3'h6 |=> REG_RDATA == msk_ff)
      else $error("mask read back wrong");
   AST_CONST_RD: assert property (REG_RD && REG_ADDR == 3'h2 |=> REG_RDATA == ca_ff)
      else $error("constant a read back wrong");
   AST_PIN_GATED: assert property (!TIMER_OUT_PIN_OE |-> !TIMER_OUT_PIN)
      else $error("pin high while disabled");
   AST_OSEL_OFF: assert property (REG_WR && REG_ADDR == 3'h1 && REG_WDATA[3:0] == 4'h0
      ##1 !(REG_WR && REG_ADDR == 3'h1) |-> ##[0:1] !TIMER_OUT_PIN_OE)
      else $error("enable stays with select zero");
   AST_RST_QUIET: assert property ($fell(SYS_RST) |-> !TIMER_OUT_PIN && !IRQ)
      else $error("outputs active after reset");
   AST_SER_PIN: assert property (SER_BASE_CLK && TIMER_OUT_PIN_OE |-> TIMER_OUT_PIN)
      else $error("base clock differs from pin");
   AST_IRQ_MASKED: assert property (msk_ff == 8'h00 && $past(msk_ff) == 8'h00 |-> !IRQ)
      else $error("interrupt with mask clear");
endmodule
bind tmo_timer tmo_timer_props #(.DIV_MID(DIV_MID), .DIV_SLOW(DIV_SLOW)) u_props (
   .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .TIMER_OUT_PIN(TIMER_OUT_PIN), .TIMER_OUT_PIN_OE(TIMER_OUT_PIN_OE),
   .SER_BASE_CLK(SER_BASE_CLK), .IRQ(IRQ)
);

// File: sim/tb.sv
// testbench of the compare timer
// assumes tmo_timer, tmo_pin_mon and the checker compiled before
`timescale 1ns/10ps
module tb;
   import tmo_pkg::*;
   logic CORE_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic [2:0] REG_ADDR = 3'h0;
   logic [7:0] REG_WDATA = 8'h00;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic mon_clr = 1'b1;
   logic [7:0] REG_RDATA, hi_len, lo_len, rises;
   logic TIMER_OUT_PIN, TIMER_OUT_PIN_OE, SER_BASE_CLK, IRQ;
   int n_fail = 0;
   int comparisons = 0;
   tmo_timer #(.DIV_MID(2), .DIV_SLOW(4)) u_dut (
      .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .TIMER_OUT_PIN(TIMER_OUT_PIN), .TIMER_OUT_PIN_OE(TIMER_OUT_PIN_OE),
      .SER_BASE_CLK(SER_BASE_CLK), .IRQ(IRQ));
   tmo_pin_mon u_mon (.clk(CORE_CLK), .clr(mon_clr), .pin(TIMER_OUT_PIN),
      .hi_len(hi_len), .lo_len(lo_len), .rises(rises));
   initial begin
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge CORE_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      #1;
      chk(REG_RDATA, exp);
   endtask
   task automatic reset_dut(input int n);
      SYS_RST <= 1'b1;
      repeat (n) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
      @(posedge CORE_CLK);
   endtask
   task automatic setup(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
      wr(3'h2, a);
      wr(3'h3, b);
      wr(3'h1, s);
      wr(3'h0, 8'h09);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(3'h1, 8'h00);
      wr(3'h1, 8'h06);
      repeat (5) @(posedge CORE_CLK);
      chk({7'h00, TIMER_OUT_PIN}, 8'h00);
      wr(3'h1, 8'hff);
      rd(3'h1, 8'h0f);
      wr(3'h6, 8'h05);
      rd(3'h6, 8'h05);
      wr(3'h2, 8'h5a);
      rd(3'h2, 8'h5a);
      $display("t_reset done");
   endtask
   task automatic t_select();
      for (int c = 0; c < 4; c++) begin
         mon_clr <= 1'b1;
         reset_dut(2);
         mon_clr <= 1'b0;
         setup(8'h03, 8'hff, {6'h01, c[1:0]});
         repeat (40) @(posedge CORE_CLK);
         if (c == 3) begin
            chk({7'h00, rises > 8'h03}, 8'h01);
         end else begin
            chk(rises, {7'h00, c == 2});
            chk({7'h00, TIMER_OUT_PIN}, {7'h00, c == 2});
         end
      end
      $display("t_select done");
   endtask
   task automatic t_pulse();
      reset_dut(2);
      wr(3'h7, 8'h04);
      setup(8'h09, 8'h03, 8'h06);
      repeat (40) @(posedge CORE_CLK);
      chk(hi_len, 8'h04);
      chk(lo_len, 8'h06);
      for (int i = 0; i < 12; i++) begin
         @(posedge CORE_CLK);
         chk({7'h00, SER_BASE_CLK}, {7'h00, TIMER_OUT_PIN});
      end
      wr(3'h0, 8'h08);
      rd(3'h1, 8'hc6);
      wr(3'h1, 8'he6);
      rd(3'h1, 8'hc6);
      wr(3'h1, 8'h06);
      rd(3'h1, 8'h06);
      rd(3'h5, 8'h03);
      wr(3'h6, 8'h01);
      repeat (2) @(posedge CORE_CLK);
      chk({7'h00, IRQ}, 8'h01);
      wr(3'h5, 8'h01);
      rd(3'h5, 8'h02);
      chk({7'h00, IRQ}, 8'h00);
      wr(3'h1, 8'h00);
      repeat (3) @(posedge CORE_CLK);
      chk({6'h00, TIMER_OUT_PIN_OE, TIMER_OUT_PIN}, 8'h00);
      $display("t_pulse done");
   endtask
   task automatic t_count();
      reset_dut(2);
      wr(3'h4, 8'hff);
      wr(3'h0, 8'h01);
      repeat (4) @(posedge CORE_CLK);
      wr(3'h0, 8'h00);
      rd(3'h5, 8'h07);
      rd(3'h1, 8'he0);
      wr(3'h4, 8'h00);
      wr(3'h0, 8'h02);
      repeat (20) @(posedge CORE_CLK);
      wr(3'h0, 8'h00);
      rd(3'h4, 8'h0b);
      $display("t_count done");
   endtask
   initial begin
      #125000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      reset_dut(20);
      t_reset();
      t_select();
      t_pulse();
      t_count();
      report_and_stop();
   end
endmodule
